//--- adc_ctrl_pkg.sv
// Package: register map, field positions, reset values and timing counts
package adc_ctrl_pkg;
    // Register indices on the plain register port
    localparam logic [2:0] ADDR_CONV_CTRL   = 3'h0;
    localparam logic [2:0] ADDR_CLK_PWR     = 3'h1;
    localparam logic [2:0] ADDR_PIN_CFG     = 3'h2;
    localparam logic [2:0] ADDR_RESULT_LO   = 3'h3;
    localparam logic [2:0] ADDR_RESULT_HI   = 3'h4;
    localparam logic [2:0] ADDR_INT_CTRL    = 3'h5;
    localparam logic [2:0] ADDR_IRQ_STATUS  = 3'h6;
    localparam logic [2:0] ADDR_IRQ_MASK    = 3'h7;
    // Field positions
    localparam int CTRL_START_BIT   = 7;
    localparam int CTRL_BUSY_BIT    = 6;
    localparam int CLK_PWRDN_BIT    = 6;
    localparam int INT_GLOBAL_BIT   = 0;
    localparam int INT_CONV_BIT     = 1;
    localparam int IRQ_DONE_BIT     = 0;
    // Reset values
    localparam logic [7:0] CLK_PWR_RESET = 8'h40;
    localparam logic [7:0] PIN_CFG_RESET = 8'h00;
    // Clock-select codes
    localparam logic [2:0] DIV_2   = 3'h0;
    localparam logic [2:0] DIV_8   = 3'h1;
    localparam logic [2:0] DIV_32  = 3'h2;
    localparam logic [2:0] DIV_1   = 3'h4;
    localparam logic [2:0] DIV_4   = 3'h5;
    localparam logic [2:0] DIV_16  = 3'h6;
    // Conversion length in conversion clock periods
    localparam logic [4:0] CONV_PERIODS = 5'h10;
    // Recommended least conversion clock period, for software only
    localparam int MIN_TAD_NS = 500;
    localparam int SYS_CLK_NS = 100;
    localparam int MIN_TAD_CYCLES = (MIN_TAD_NS + SYS_CLK_NS - 1) / SYS_CLK_NS;
endpackage : adc_ctrl_pkg

//--- conv_clock_divider.sv
// Conversion clock enable generator from the system clock
`timescale 1ns/1ps
module conv_clock_divider
    import adc_ctrl_pkg::*;
(
    // Clock and reset
    input  wire logic       sys_clk,
    input  wire logic       rst,
    // Control
    input  wire logic       run,
    input  wire logic [2:0] conv_clock_divider_select,
    // Enable pulse out
    output logic            conv_tick
);
    logic [4:0] count;
    logic [4:0] limit;
    logic       valid_code;

    // Terminal count per code; undefined codes stop the clock
    always_comb begin
        valid_code = 1'b1;
        case (conv_clock_divider_select) // [RULE5]
            DIV_1:   limit = 5'h00;
            DIV_2:   limit = 5'h01;
            DIV_4:   limit = 5'h03;
            DIV_8:   limit = 5'h07;
            DIV_16:  limit = 5'h0f;
            DIV_32:  limit = 5'h1f;
            default: begin
                limit      = 5'h00;
                valid_code = 1'b0; // [RULE18]
            end
        endcase
    end

    // Free counter restarted whenever the sequencer is idle
    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            count <= 5'h00;
        end else if (!run || !valid_code || count >= limit) begin
            count <= 5'h00;
        end else begin
            count <= count + 5'h01;
        end
    end

    assign conv_tick = run && valid_code && (count >= limit); // [RULE5] [RULE18]

    // Undefined codes must never let the conversion advance
    property p_no_tick_undef;
        @(posedge sys_clk) disable iff (rst)
        (conv_clock_divider_select == 3'h3 || conv_clock_divider_select == 3'h7)
            |-> !conv_tick;
    endproperty
    a_no_tick_undef: assert property (p_no_tick_undef) // [RULE18]
        else $error("tick on undefined divider code");
endmodule : conv_clock_divider

//--- adc_conversion_control.sv
// Conversion control: start sequencing, busy flag, interrupt, pins
// Contract
// [RULE1] Start bit going 0 then 1 then 0 begins one conversion.
// [RULE2] While start is high, converter held in reset and busy forced to 1.
// [RULE3] Busy flag cleared by hardware when conversion finishes.
// [RULE4] End of conversion sets request flag; interrupt only when enabled.
// [RULE5] Clock-select code divides system clock by 2,8,32,1,4,16.
// [RULE6] Power-down bit 0 enables converter, 1 powers it down.
// [RULE7] Software should keep conversion clock period at least 0.5 us.
// [RULE8] One analog/digital configuration bit per pin, eight pins.
// [RULE9] Pull-up disconnected for any pin configured as analog.
// [RULE10] Analog configuration overrides the pin direction setting.
// [RULE11] Software pulses start after every channel-select change.
// [RULE12] Channel-select field connects one analog input to converter.
// [RULE13] Software sets global and converter interrupt enables to use it.
// [RULE14] Software ensures start bit is 0 before the start sequence.
// [RULE15] After busy goes low, result stands in low and high registers.
// [RULE16] Conversion takes 16 conversion clock periods from start release.
// [RULE17] Channel code 000 selects input 0 up to 111 for input 7.
// [RULE18] Undefined clock codes stop the clock; busy stays set.
//
// The address map and strobed register access are this design's own decisions.
`timescale 1ns/1ps
module adc_conversion_control
    import adc_ctrl_pkg::*;
#(
    parameter int RESULT_BITS = 12,
    parameter int PIN_COUNT   = 8
)(
    // Clock and reset
    input  wire logic                   sys_clk,
    input  wire logic                   rst,
    // Register port
    input  wire logic [2:0]             reg_addr,
    input  wire logic [7:0]             reg_wdata,
    input  wire logic                   reg_wr,
    input  wire logic                   reg_rd,
    output logic [7:0]                  reg_rdata,
    // Analog core
    input  wire logic [RESULT_BITS-1:0] core_result,
    output logic                        core_reset,
    output logic                        core_power_on,
    output logic                        core_sample_tick,
    output logic [2:0]                  input_channel_select,
    // Port pins
    input  wire logic [PIN_COUNT-1:0]   port_pullup_cfg,
    input  wire logic [PIN_COUNT-1:0]   port_output_cfg,
    output logic [PIN_COUNT-1:0]        pin_pullup_en,
    output logic [PIN_COUNT-1:0]        pin_output_en,
    output logic [PIN_COUNT-1:0]        pin_analog_route,
    // Interrupt
    output logic                        irq
);
    // Elaboration checks: the byte-wide register layout serves only these sizes
    if (RESULT_BITS < 1 || RESULT_BITS > 16) begin : g_bad_result_bits
        $error("RESULT_BITS must lie in 1..16");
    end
    if (PIN_COUNT != 8) begin : g_bad_pin_count
        $error("PIN_COUNT must be 8");
    end

    // One-hot sequencer states
    typedef enum logic [2:0] {
        ST_IDLE  = 3'b001,
        ST_RESET = 3'b010,
        ST_CONV  = 3'b100
    } conv_state_t;

    conv_state_t                state;
    logic                       start_bit;
    logic                       conversion_busy_flag;
    logic [2:0]                 conv_clock_divider_select;
    logic                       converter_power_down;
    logic [PIN_COUNT-1:0]       pin_analog_config;
    logic                       global_interrupt_enable;
    logic                       converter_interrupt_enable;
    logic [7:0]                 irq_status;
    logic [7:0]                 irq_mask;
    logic [RESULT_BITS-1:0]     result;
    logic [4:0]                 period_count;
    logic                       conv_tick;
    logic                       conv_done;
    logic                       wr_ctrl;

    function automatic logic is_access(input logic strobe, input logic [2:0] a,
                                       input logic [2:0] target);
        return strobe && (a == target);
    endfunction : is_access

    assign wr_ctrl = is_access(reg_wr, reg_addr, ADDR_CONV_CTRL);

    // Software-written control fields
    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            start_bit                 <= 1'b0;
            input_channel_select      <= 3'h0;
            conv_clock_divider_select <= CLK_PWR_RESET[2:0];
            converter_power_down      <= CLK_PWR_RESET[CLK_PWRDN_BIT];
            pin_analog_config         <= PIN_CFG_RESET;
            global_interrupt_enable   <= 1'b0;
            converter_interrupt_enable <= 1'b0;
            irq_mask                  <= 8'h00;
        end else if (reg_wr) begin
            case (reg_addr)
                ADDR_CONV_CTRL: begin
                    start_bit            <= reg_wdata[CTRL_START_BIT];
                    input_channel_select <= reg_wdata[2:0]; // [RULE12] [RULE17]
                end
                ADDR_CLK_PWR: begin
                    conv_clock_divider_select <= reg_wdata[2:0];
                    converter_power_down      <= reg_wdata[CLK_PWRDN_BIT];
                end
                ADDR_PIN_CFG:  pin_analog_config <= reg_wdata; // [RULE8]
                ADDR_INT_CTRL: begin
                    global_interrupt_enable    <= reg_wdata[INT_GLOBAL_BIT];
                    converter_interrupt_enable <= reg_wdata[INT_CONV_BIT];
                end
                ADDR_IRQ_MASK: irq_mask <= reg_wdata;
                default: ;
            endcase
        end
    end

    // Sequencer: reset while start high, run on its release
    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            state <= ST_IDLE;
        end else begin
            case (state)
                ST_IDLE:  if (start_bit) state <= ST_RESET;
                ST_RESET: if (!start_bit) state <= ST_CONV; // [RULE1]
                ST_CONV: begin
                    if (start_bit) begin
                        state <= ST_RESET; // [RULE2]
                    end else if (conv_done) begin
                        state <= ST_IDLE;
                    end
                end
                default: state <= ST_IDLE;
            endcase
        end
    end

    conv_clock_divider u_div (
        .sys_clk                   (sys_clk),
        .rst                       (rst),
        .run                       (state == ST_CONV && !converter_power_down),
        .conv_clock_divider_select (conv_clock_divider_select),
        .conv_tick                 (conv_tick)
    );

    // Count conversion clock periods since start release
    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            period_count <= 5'h00;
        end else if (state != ST_CONV) begin
            period_count <= 5'h00;
        end else if (conv_tick) begin
            period_count <= period_count + 5'h01; // [RULE16]
        end
    end

    assign conv_done = (state == ST_CONV) && conv_tick
                       && (period_count == CONV_PERIODS - 5'h01); // [RULE16]

    // Busy flag: set by start, cleared only by completion; powers up set
    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            conversion_busy_flag <= 1'b1;
        end else if (start_bit) begin
            conversion_busy_flag <= 1'b1; // [RULE2]
        end else if (conv_done) begin
            conversion_busy_flag <= 1'b0; // [RULE3]
        end
    end

    // Capture result at completion so it stands once busy falls
    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            result <= '0;
        end else if (conv_done) begin
            result <= core_result; // [RULE15]
        end
    end

    // Sticky status: completion wins over a clearing read
    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            irq_status <= 8'h00;
        end else begin
            if (is_access(reg_rd, reg_addr, ADDR_IRQ_STATUS)) begin
                irq_status <= 8'h00;
            end
            if (conv_done) begin
                irq_status[IRQ_DONE_BIT] <= 1'b1; // [RULE4]
            end
        end
    end

    // Interrupt only when both enables and the mask allow it
    assign irq = global_interrupt_enable && converter_interrupt_enable
                 && |(irq_status & irq_mask); // [RULE4]

    // Read data, one cycle after the strobe
    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            reg_rdata <= 8'h00;
        end else if (reg_rd) begin
            case (reg_addr)
                ADDR_CONV_CTRL:  reg_rdata <= {start_bit, conversion_busy_flag, 3'h0,
                                               input_channel_select};
                ADDR_CLK_PWR:    reg_rdata <= {1'b0, converter_power_down, 3'h0,
                                               conv_clock_divider_select};
                ADDR_PIN_CFG:    reg_rdata <= pin_analog_config;
                ADDR_RESULT_LO:  reg_rdata <= 8'((16'(result)) & 16'h00ff);
                ADDR_RESULT_HI:  reg_rdata <= 8'((16'(result)) >> 8);
                ADDR_INT_CTRL:   reg_rdata <= {6'h00, converter_interrupt_enable,
                                               global_interrupt_enable};
                ADDR_IRQ_STATUS: reg_rdata <= irq_status;
                ADDR_IRQ_MASK:   reg_rdata <= irq_mask;
                default:         reg_rdata <= 8'h00;
            endcase
        end else begin
            reg_rdata <= 8'h00;
        end
    end

    // Core controls
    assign core_power_on    = !converter_power_down; // [RULE6]
    // Reset follows the start bit at once, not one state step later
    assign core_reset       = start_bit || (state == ST_RESET) || converter_power_down; // [RULE2]
    assign core_sample_tick = conv_tick;

    // Pin overrides: analog pins lose pull-up and output drive
    assign pin_analog_route = pin_analog_config; // [RULE8]
    assign pin_pullup_en    = port_pullup_cfg & ~pin_analog_config; // [RULE9]
    assign pin_output_en    = port_output_cfg & ~pin_analog_config; // [RULE10]

    // Assertions
    property p_busy_while_start;
        @(posedge sys_clk) disable iff (rst)
        $past(start_bit) |-> conversion_busy_flag;
    endproperty
    a_busy_while_start: assert property (p_busy_while_start) // [RULE2]
        else $error("busy low while start high");

    property p_reset_while_start;
        @(posedge sys_clk) disable iff (rst)
        (state == ST_CONV && start_bit) |=> core_reset;
    endproperty
    a_reset_while_start: assert property (p_reset_while_start) // [RULE2]
        else $error("core not reset while start high");

    property p_release_starts;
        @(posedge sys_clk) disable iff (rst)
        (state == ST_RESET && !start_bit) |=> state == ST_CONV;
    endproperty
    a_release_starts: assert property (p_release_starts) // [RULE1]
        else $error("start release did not begin conversion");

    property p_done_clears_busy;
        @(posedge sys_clk) disable iff (rst)
        (conv_done && !start_bit) |=> !conversion_busy_flag && irq_status[IRQ_DONE_BIT];
    endproperty
    a_done_clears_busy: assert property (p_done_clears_busy) // [RULE3]
        else $error("busy or status wrong after completion");

    // Divide-by-one run ends sixteen cycles after the release is taken
    property p_sixteen_periods;
        @(posedge sys_clk) disable iff (rst)
        (state == ST_RESET && !start_bit && !reg_wr && !converter_power_down
            && conv_clock_divider_select == DIV_1)
        |-> ##16 (conv_done || start_bit || converter_power_down
            || conv_clock_divider_select != DIV_1);
    endproperty
    a_sixteen_periods: assert property (p_sixteen_periods) // [RULE16]
        else $error("conversion not sixteen periods");

    property p_irq_gated;
        @(posedge sys_clk) disable iff (rst)
        irq |-> global_interrupt_enable && converter_interrupt_enable;
    endproperty
    a_irq_gated: assert property (p_irq_gated) // [RULE4]
        else $error("interrupt without enables");

    property p_pullup_off;
        @(posedge sys_clk) disable iff (rst)
        (pin_pullup_en & pin_analog_config) == 8'h00;
    endproperty
    a_pullup_off: assert property (p_pullup_off) // [RULE9]
        else $error("pull-up on analog pin");

    property p_dir_override;
        @(posedge sys_clk) disable iff (rst)
        (pin_output_en & pin_analog_config) == 8'h00;
    endproperty
    a_dir_override: assert property (p_dir_override) // [RULE10]
        else $error("output drive on analog pin");

    property p_power;
        @(posedge sys_clk) disable iff (rst)
        converter_power_down |-> !core_power_on && !conv_tick;
    endproperty
    a_power: assert property (p_power) // [RULE6]
        else $error("converter active while powered down");

    property p_result_held;
        @(posedge sys_clk) disable iff (rst)
        (!conversion_busy_flag && !conv_done) |=> $stable(result);
    endproperty
    a_result_held: assert property (p_result_held) // [RULE15]
        else $error("result changed while idle");

    property p_start_follows_write;
        @(posedge sys_clk) disable iff (rst)
        wr_ctrl |=> start_bit == $past(reg_wdata[CTRL_START_BIT]);
    endproperty
    a_start_follows_write: assert property (p_start_follows_write) // [RULE1]
        else $error("start bit did not follow its write");

    property p_reset_level;
        @(posedge sys_clk) disable iff (rst)
        start_bit |-> core_reset;
    endproperty
    a_reset_level: assert property (p_reset_level) // [RULE2]
        else $error("core not reset while start bit high");

    property p_channel_route;
        @(posedge sys_clk) disable iff (rst)
        !wr_ctrl |=> $stable(input_channel_select);
    endproperty
    a_channel_route: assert property (p_channel_route) // [RULE12]
        else $error("channel changed without a control write");

    // Stopped conversion clock must leave the busy flag standing
    property p_undef_holds_busy;
        @(posedge sys_clk) disable iff (rst)
        (conversion_busy_flag && (conv_clock_divider_select == 3'h3
            || conv_clock_divider_select == 3'h7)) |=> conversion_busy_flag;
    endproperty
    a_undef_holds_busy: assert property (p_undef_holds_busy) // [RULE18]
        else $error("busy fell with the conversion clock stopped");

    property p_irq_level;
        @(posedge sys_clk) disable iff (rst)
        (global_interrupt_enable && converter_interrupt_enable
            && (irq_status & irq_mask) != 8'h00) |-> irq;
    endproperty
    a_irq_level: assert property (p_irq_level) // [RULE4]
        else $error("interrupt low with an enabled request pending");
endmodule : adc_conversion_control

//--- tb.sv
// Self-checking testbench for the conversion control block
`timescale 1ns/1ps
module tb
    import adc_ctrl_pkg::*;
;
    // Clock, reset and register port
    logic        sys_clk = 1'b0;
    logic        rst = 1'b1;
    logic [2:0]  reg_addr = 3'h0;
    logic [7:0]  reg_wdata = 8'h00;
    logic        reg_wr = 1'b0;
    logic        reg_rd = 1'b0;
    logic [7:0]  reg_rdata;
    // Analog core and pins
    logic [11:0] core_result = 12'h000;
    logic        core_reset;
    logic        core_power_on;
    logic        core_sample_tick;
    logic [2:0]  input_channel_select;
    logic [7:0]  port_pullup_cfg = 8'h00;
    logic [7:0]  port_output_cfg = 8'h00;
    logic [7:0]  pin_pullup_en;
    logic [7:0]  pin_output_en;
    logic [7:0]  pin_analog_route;
    logic        irq;
    // Bookkeeping
    int          n_fail = 0;
    int          samples_checked = 0;
    int          ticks = 0;
    int          cyc = 0;
    logic        counting = 1'b0;
    logic [7:0]  d;

    adc_conversion_control uut (
        .sys_clk              (sys_clk),
        .rst                  (rst),
        .reg_addr             (reg_addr),
        .reg_wdata            (reg_wdata),
        .reg_wr               (reg_wr),
        .reg_rd               (reg_rd),
        .reg_rdata            (reg_rdata),
        .core_result          (core_result),
        .core_reset           (core_reset),
        .core_power_on        (core_power_on),
        .core_sample_tick     (core_sample_tick),
        .input_channel_select (input_channel_select),
        .port_pullup_cfg      (port_pullup_cfg),
        .port_output_cfg      (port_output_cfg),
        .pin_pullup_en        (pin_pullup_en),
        .pin_output_en        (pin_output_en),
        .pin_analog_route     (pin_analog_route),
        .irq                  (irq)
    );

    // 10 MHz system clock
    always #50 sys_clk = ~sys_clk;

    // Cycle and tick counters for conversion timing
    always @(posedge sys_clk) begin
        if (counting) begin
            cyc <= cyc + 1;
            if (core_sample_tick === 1'b1) begin
                ticks <= ticks + 1;
            end
        end
    end

    task automatic check(input logic [15:0] seen, input logic [15:0] exp);
        samples_checked++;
        if (seen !== exp) begin
            n_fail++;
            $display("BAD t=%0t seen %h expected %h", $time, seen, exp);
        end
    endtask : check

    // One-cycle write strobe, launched after an edge
    task automatic wr(input logic [2:0] a, input logic [7:0] v);
        @(posedge sys_clk);
        reg_addr  <= a;
        reg_wdata <= v;
        reg_wr    <= 1'b1;
        @(posedge sys_clk);
        reg_wr    <= 1'b0;
    endtask : wr

    // Read data stands only in the cycle after the strobe
    task automatic rd(input logic [2:0] a, output logic [7:0] v);
        @(posedge sys_clk);
        reg_addr <= a;
        reg_rd   <= 1'b1;
        @(posedge sys_clk);
        reg_rd   <= 1'b0;
        #1;
        v = reg_rdata;
    endtask : rd

    // Start bit low, up, then down; counting begins at the release edge
    task automatic kick(input logic [2:0] chan);
        wr(ADDR_CONV_CTRL, {5'h00, chan});
        wr(ADDR_CONV_CTRL, {5'h10, chan});
        rd(ADDR_CONV_CTRL, d);
        check(d, {2'b11, 3'b000, chan});
        check(core_reset, 1'b1);
        wr(ADDR_CONV_CTRL, {5'h00, chan});
        #1;
        ticks    = 0;
        cyc      = 0;
        counting = 1'b1;
    endtask : kick

    task automatic wait_cycles(input int n);
        repeat (n) @(posedge sys_clk);
        #1;
    endtask : wait_cycles

    // Full conversion seen on the interrupt line; input moves after capture
    task automatic conv(input logic [2:0] code, input int n, input logic [2:0] chan,
                        input logic [11:0] value);
        wr(ADDR_CLK_PWR, {5'h00, code});
        core_result <= value;
        #1;
        check(core_power_on, 1'b1);
        kick(chan);
        check(input_channel_select, chan);
        for (int i = 0; i < 700 && irq !== 1'b1; i++) begin
            @(posedge sys_clk);
            #1;
        end
        counting = 1'b0;
        check(irq, 1'b1);
        check(16'(cyc), 16'(16 * n + 1));
        check(16'(ticks), 16'h0010);
        @(posedge sys_clk);
        core_result <= ~value;
        rd(ADDR_CONV_CTRL, d);
        check(d, {5'h00, chan});
        rd(ADDR_RESULT_LO, d);
        check(d, value[7:0]);
        rd(ADDR_RESULT_HI, d);
        check(d, {4'h0, value[11:8]});
        rd(ADDR_IRQ_STATUS, d);
        check(d, 8'h01);
        check(irq, 1'b0);
        $display("conversion with divider %0d done", n);
    endtask : conv

    task automatic wrap_up;
        $display("checks %0d mismatches %0d", samples_checked, n_fail);
        if (n_fail == 0 && samples_checked > 0) begin
            $display("Test passed");
        end else begin
            $display("Test failed");
        end
        $finish;
    endtask : wrap_up

    // Longest path is well under this span
    initial begin
        #(20000 * 100);
        n_fail++;
        wrap_up();
    end

    initial begin
        logic [2:0] codes [6];
        int         divs  [6];
        codes = '{DIV_2, DIV_8, DIV_32, DIV_1, DIV_4, DIV_16};
        divs  = '{2, 8, 32, 1, 4, 16};
        repeat (2) @(posedge sys_clk);
        rst <= 1'b0;
        #1;
        check(irq, 1'b0);
        check(core_power_on, 1'b0);
        rd(ADDR_CONV_CTRL, d);
        check(d, 8'h40);
        rd(ADDR_CLK_PWR, d);
        check(d, CLK_PWR_RESET);
        $display("reset values done");
        // Analog pins drop pull-up and output drive
        @(posedge sys_clk);
        port_pullup_cfg <= 8'hff;
        port_output_cfg <= 8'h0f;
        wr(ADDR_PIN_CFG, 8'ha5);
        #1;
        check(pin_analog_route, 8'ha5);
        check(pin_pullup_en, 8'h5a);
        check(pin_output_en, 8'h0a);
        rd(ADDR_PIN_CFG, d);
        check(d, 8'ha5);
        $display("pin configuration done");
        for (int c = 0; c < 8; c++) begin
            wr(ADDR_CONV_CTRL, c[7:0]);
            #1;
            check(input_channel_select, c[2:0]);
        end
        $display("channel select done");
        wr(ADDR_INT_CTRL, 8'h03);
        wr(ADDR_IRQ_MASK, 8'h01);
        for (int i = 0; i < 6; i++) begin
            conv(codes[i], divs[i], 3'(i + 1), 12'h5a0 + 12'(i * 17));
        end
        // Masked completion: flag set, line quiet until mask and both enables
        wr(ADDR_IRQ_MASK, 8'h00);
        wr(ADDR_CLK_PWR, {5'h00, DIV_8});
        kick(3'h0);
        wait_cycles(140);
        counting = 1'b0;
        check(irq, 1'b0);
        wr(ADDR_IRQ_MASK, 8'h01);
        wr(ADDR_INT_CTRL, 8'h01);
        #1;
        check(irq, 1'b0);
        wr(ADDR_INT_CTRL, 8'h03);
        #1;
        check(irq, 1'b1);
        rd(ADDR_IRQ_STATUS, d);
        check(d, 8'h01);
        rd(ADDR_CONV_CTRL, d);
        check(d, 8'h00);
        $display("masked interrupt done");
        // Undefined clock codes never finish
        for (int k = 0; k < 2; k++) begin
            wr(ADDR_CLK_PWR, k == 0 ? 8'h03 : 8'h07);
            kick(3'h2);
            wait_cycles(100);
            counting = 1'b0;
            check(16'(ticks), 16'h0000);
            rd(ADDR_CONV_CTRL, d);
            check(d, 8'h42);
        end
        $display("undefined clock codes done");
        // Powered down: core held, no progress; power-up lets it finish
        wr(ADDR_CLK_PWR, 8'h44);
        #1;
        check(core_power_on, 1'b0);
        kick(3'h0);
        wait_cycles(50);
        counting = 1'b0;
        check(16'(ticks), 16'h0000);
        check(core_reset, 1'b1);
        rd(ADDR_CONV_CTRL, d);
        check(d, 8'h40);
        wr(ADDR_CLK_PWR, {5'h00, DIV_1});
        wait_cycles(20);
        rd(ADDR_CONV_CTRL, d);
        check(d, 8'h00);
        $display("power down done");
        wrap_up();
    end
endmodule : tb
